// ==== input_capture_control.v ====
// input capture control: apb registers, three channels, interrupt
//
// Function
// - per-channel enable bits at 6, 5, 4
// - disabled channel detects nothing, no flag
// - selected edge sets channel event flag
// - event flags at bits 2, 1, 0
// - edge codes fall, rise, both
// - edge fields at 5:4, 3:2, 1:0
// - filter enables at bits 6, 5, 4
// - filter off means unfiltered detection
// - edge select resets to zero
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "input_capture_consts.vh"

module input_capture_control (
   input wire core_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`CAP_AW-1:0] paddr,
   input wire [`CAP_DW-1:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output wire [`CAP_DW-1:0] prdata,
   output wire pslverr,
   input wire [`CAP_NCH-1:0] captureIn,
   output wire irq
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   reg [`CAP_NCH-1:0] chanOn_q;
   reg [`CAP_NCH-1:0] chanOn_d;
   reg [`CAP_NCH-1:0] eventFlag_q;
   reg [`CAP_NCH-1:0] eventFlag_d;
   reg [`CAP_SEL_MSB:0] edgeSel_q;
   reg [`CAP_SEL_MSB:0] edgeSel_d;
   reg [`CAP_NCH-1:0] filterOn_q;
   reg [`CAP_NCH-1:0] filterOn_d;
   reg [`CAP_NCH-1:0] intStat_q;
   reg [`CAP_NCH-1:0] intStat_d;
   reg [`CAP_NCH-1:0] intMask_q;
   reg [`CAP_NCH-1:0] intMask_d;
   reg [`CAP_DW-1:0] rdata_q;
   reg [`CAP_DW-1:0] rdata_d;
   reg err_q;
   reg err_d;
   reg irq_q;

   wire [`CAP_NCH-1:0] edgeHit;

   // ---------------------------------------------------------------
   // reset images, cut to the width of each field
   // ---------------------------------------------------------------
   localparam [7:0] RST_ENFLAG = `CAP_RST_ENFLAG;
   localparam [7:0] RST_EDGESEL = `CAP_RST_EDGESEL;
   localparam [7:0] RST_FILTER = `CAP_RST_FILTER;
   localparam [`CAP_NCH-1:0] RST_ON =
      RST_ENFLAG[`CAP_ON_MSB:`CAP_ON_LSB];
   localparam [`CAP_NCH-1:0] RST_FLAG =
      RST_ENFLAG[`CAP_FLAG_MSB:`CAP_FLAG_LSB];
   localparam [`CAP_SEL_MSB:0] RST_SEL =
      RST_EDGESEL[`CAP_SEL_MSB:0];
   localparam [`CAP_NCH-1:0] RST_FILT =
      RST_FILTER[`CAP_FILT_MSB:`CAP_FILT_LSB];

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire setup;
   wire access;
   wire wrLane;
   wire aligned;
   wire hitEnFlag;
   wire hitEdgeSel;
   wire hitFilter;
   wire hitIntStat;
   wire hitIntMask;
   wire mapped;
   wire wrEnFlag;
   wire wrEdgeSel;
   wire wrFilter;
   wire wrIntStat;
   wire wrIntMask;
   wire [7:0] wbyte;

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign aligned = (paddr[1:0] == 2'h0);
   assign hitEnFlag = aligned & (paddr[`CAP_AW-1:2] == `CAP_IDX_ENFLAG);
   assign hitEdgeSel = aligned & (paddr[`CAP_AW-1:2] == `CAP_IDX_EDGESEL);
   assign hitFilter = aligned & (paddr[`CAP_AW-1:2] == `CAP_IDX_FILTER);
   assign hitIntStat = aligned & (paddr[`CAP_AW-1:2] == `CAP_IDX_INTSTAT);
   assign hitIntMask = aligned & (paddr[`CAP_AW-1:2] == `CAP_IDX_INTMASK);
   assign mapped = hitEnFlag | hitEdgeSel | hitFilter | hitIntStat |
                   hitIntMask;

   // only byte lane 0 carries register bits; other lanes are ignored
   assign wrLane = access & pwrite & pstrb[0] & mapped;
   assign wrEnFlag = wrLane & hitEnFlag;
   assign wrEdgeSel = wrLane & hitEdgeSel;
   assign wrFilter = wrLane & hitFilter;
   assign wrIntStat = wrLane & hitIntStat;
   assign wrIntMask = wrLane & hitIntMask;
   assign wbyte = pwdata[7:0];

   // zero wait states: every access completes in its first cycle
   assign pready = access;
   assign prdata = rdata_q;
   assign pslverr = err_q & access;
   assign irq = irq_q;

   // ---------------------------------------------------------------
   // per-channel field views
   // ---------------------------------------------------------------
   wire chan0On;
   wire chan1On;
   wire chan2On;
   wire chan0EventFlag;
   wire chan1EventFlag;
   wire chan2EventFlag;
   wire [1:0] chan0EdgeSel;
   wire [1:0] chan1EdgeSel;
   wire [1:0] chan2EdgeSel;
   wire chan0FilterOn;
   wire chan1FilterOn;
   wire chan2FilterOn;

   assign chan0On = chanOn_q[0];
   assign chan1On = chanOn_q[1];
   assign chan2On = chanOn_q[2];
   assign chan0EventFlag = eventFlag_q[0];
   assign chan1EventFlag = eventFlag_q[1];
   assign chan2EventFlag = eventFlag_q[2];
   assign chan0EdgeSel = edgeSel_q[1:0];
   assign chan1EdgeSel = edgeSel_q[3:2];
   assign chan2EdgeSel = edgeSel_q[5:4];
   assign chan0FilterOn = filterOn_q[0];
   assign chan1FilterOn = filterOn_q[1];
   assign chan2FilterOn = filterOn_q[2];

   // ---------------------------------------------------------------
   // channel instances
   // ---------------------------------------------------------------
   capture_channel u_chan0 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .capIn(captureIn[0]),
      .chanOn(chan0On),
      .filterOn(chan0FilterOn),
      .edgeSel(chan0EdgeSel),
      .edgeHit(edgeHit[0])
   );

   capture_channel u_chan1 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .capIn(captureIn[1]),
      .chanOn(chan1On),
      .filterOn(chan1FilterOn),
      .edgeSel(chan1EdgeSel),
      .edgeHit(edgeHit[1])
   );

   capture_channel u_chan2 (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .capIn(captureIn[2]),
      .chanOn(chan2On),
      .filterOn(chan2FilterOn),
      .edgeSel(chan2EdgeSel),
      .edgeHit(edgeHit[2])
   );

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always @* begin
      chanOn_d = chanOn_q;
      edgeSel_d = edgeSel_q;
      filterOn_d = filterOn_q;
      intMask_d = intMask_q;
      if (wrEnFlag) begin
         chanOn_d = wbyte[`CAP_ON_MSB:`CAP_ON_LSB];
      end
      if (wrEdgeSel) begin
         edgeSel_d = wbyte[`CAP_SEL_MSB:0];
      end
      if (wrFilter) begin
         filterOn_d = wbyte[`CAP_FILT_MSB:`CAP_FILT_LSB];
      end
      if (wrIntMask) begin
         intMask_d = wbyte[`CAP_NCH-1:0];
      end
   end

   // ---------------------------------------------------------------
   // event flags and interrupt status
   // ---------------------------------------------------------------
   always @* begin
      eventFlag_d = eventFlag_q;
      intStat_d = intStat_q;
      if (wrEnFlag) begin
         eventFlag_d = wbyte[`CAP_FLAG_MSB:`CAP_FLAG_LSB];
      end
      if (wrIntStat) begin
         intStat_d = intStat_q & ~wbyte[`CAP_NCH-1:0];
      end
      eventFlag_d = eventFlag_d | edgeHit;
      intStat_d = intStat_d | edgeHit;
   end

   // ---------------------------------------------------------------
   // interrupt request
   // ---------------------------------------------------------------
   wire [`CAP_NCH-1:0] pendNext;

   // status is sticky; the mask gates only the output, never capture
   assign pendNext = intStat_d & intMask_d;

   // ---------------------------------------------------------------
   // read data, sampled in the setup cycle
   // ---------------------------------------------------------------
   always @* begin
      rdata_d = {`CAP_DW{1'b0}};
      err_d = 1'b0;
      if (setup) begin
         if (!mapped) begin
            err_d = 1'b1;
         end
         if (hitEnFlag) begin
            rdata_d[`CAP_ON_MSB:`CAP_ON_LSB] = chanOn_q;
            rdata_d[`CAP_FLAG_MSB:`CAP_FLAG_LSB] = {chan2EventFlag,
               chan1EventFlag, chan0EventFlag};
         end
         if (hitEdgeSel) begin
            rdata_d[`CAP_SEL_MSB:0] = edgeSel_q;
         end
         if (hitFilter) begin
            rdata_d[`CAP_FILT_MSB:`CAP_FILT_LSB] = filterOn_q;
         end
         if (hitIntStat) begin
            rdata_d[`CAP_NCH-1:0] = intStat_q;
         end
         if (hitIntMask) begin
            rdata_d[`CAP_NCH-1:0] = intMask_q;
         end
      end else if (access) begin
         rdata_d = rdata_q;
         err_d = err_q;
      end
   end

   // ---------------------------------------------------------------
   // flip-flops
   // ---------------------------------------------------------------
   // channel enables
   always @(posedge core_clk) begin
      if (!rst_n) begin
         chanOn_q <= RST_ON;
      end else begin
         chanOn_q <= chanOn_d;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         eventFlag_q <= RST_FLAG;
      end else begin
         eventFlag_q <= eventFlag_d;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         edgeSel_q <= RST_SEL;
      end else begin
         edgeSel_q <= edgeSel_d;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         filterOn_q <= RST_FILT;
      end else begin
         filterOn_q <= filterOn_d;
      end
   end

   // sticky interrupt status
   always @(posedge core_clk) begin
      if (!rst_n) begin
         intStat_q <= `CAP_RST_INT;
      end else begin
         intStat_q <= intStat_d;
      end
   end

   // interrupt mask
   always @(posedge core_clk) begin
      if (!rst_n) begin
         intMask_q <= `CAP_RST_INT;
      end else begin
         intMask_q <= intMask_d;
      end
   end

   // read data held through the access phase
   always @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= {`CAP_DW{1'b0}};
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // refusal of unmapped or misaligned access
   always @(posedge core_clk) begin
      if (!rst_n) begin
         err_q <= 1'b0;
      end else begin
         err_q <= err_d;
      end
   end

   // built from next values so irq moves with the stored status
   always @(posedge core_clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |pendNext;
      end
   end

endmodule // input_capture_control

// ==== input_capture_consts.vh ====
// register map, field positions, reset values and timing for input capture
`ifndef INPUT_CAPTURE_CONSTS_VH
`define INPUT_CAPTURE_CONSTS_VH

// ---------------------------------------------------------------
// register indexes; byte address is four times the index
// ---------------------------------------------------------------
`define CAP_IDX_ENFLAG 10'h092
`define CAP_IDX_EDGESEL 10'h093
`define CAP_IDX_FILTER 10'h094
`define CAP_IDX_INTSTAT 10'h0a0
`define CAP_IDX_INTMASK 10'h0a1

// ---------------------------------------------------------------
// bus widths and channel count
// ---------------------------------------------------------------
`define CAP_AW 12
`define CAP_DW 32
`define CAP_NCH 3

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CAP_ON_LSB 4
`define CAP_ON_MSB 6
`define CAP_FLAG_LSB 0
`define CAP_FLAG_MSB 2
`define CAP_SEL_MSB 5
`define CAP_FILT_LSB 4
`define CAP_FILT_MSB 6

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CAP_RST_ENFLAG 8'h00
`define CAP_RST_EDGESEL 8'h00
`define CAP_RST_FILTER 8'h00
`define CAP_RST_INT 3'h0

// ---------------------------------------------------------------
// edge selection codes
// ---------------------------------------------------------------
`define CAP_SEL_FALL 2'h0
`define CAP_SEL_RISE 2'h1
`define CAP_SEL_BOTH 2'h2
`define CAP_SEL_RSVD 2'h3

// ---------------------------------------------------------------
// noise filter: stable samples needed before a level passes
// ---------------------------------------------------------------
`define CAP_FILT_LEN 4
`define CAP_FILT_CW 3

`endif

// ==== capture_channel.v ====
// one capture channel: synchroniser, noise filter, edge detector
`timescale 1ns/1ps
`include "input_capture_consts.vh"

module capture_channel (
   input wire core_clk,
   input wire rst_n,
   input wire capIn,
   input wire chanOn,
   input wire filterOn,
   input wire [1:0] edgeSel,
   output wire edgeHit
);

   reg sync1_q;
   reg sync2_q;
   reg filt_q;
   reg [`CAP_FILT_CW-1:0] cnt_q;
   reg prev_q;
   reg hit_q;
   wire level;
   wire rise;
   wire fall;
   reg match;

   // ---------------------------------------------------------------
   // synchroniser
   // ---------------------------------------------------------------
   // two-stage sync
   always @(posedge core_clk) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= capIn;
         sync2_q <= sync1_q;
      end
   end

   // ---------------------------------------------------------------
   // noise filter
   // ---------------------------------------------------------------
   // stability count filter
   always @(posedge core_clk) begin
      if (!rst_n) begin
         filt_q <= 1'b0;
         cnt_q <= {`CAP_FILT_CW{1'b0}};
      end else if (sync2_q == filt_q) begin
         cnt_q <= {`CAP_FILT_CW{1'b0}};
      end else if (cnt_q == (`CAP_FILT_LEN - 1)) begin
         filt_q <= sync2_q;
         cnt_q <= {`CAP_FILT_CW{1'b0}};
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign level = filterOn ? filt_q : sync2_q;

   // ---------------------------------------------------------------
   // edge detection
   // ---------------------------------------------------------------
   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;

   always @* begin
      case (edgeSel)
         `CAP_SEL_FALL: match = fall;
         `CAP_SEL_RISE: match = rise;
         `CAP_SEL_BOTH: match = rise | fall;
         default: match = 1'b0;
      endcase
   end

   // prev always tracks so enabling a channel raises no stale edge
   always @(posedge core_clk) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
         hit_q <= 1'b0;
      end else begin
         prev_q <= level;
         hit_q <= match & chanOn;
      end
   end

   assign edgeHit = hit_q;

endmodule // capture_channel

// ==== capture_source.sv ====
// external capture inputs seen by the block
`timescale 1ns/1ps
module capture_source (
   input wire logic core_clk,
   input wire logic [2:0] level,
   output logic [2:0] captureIn
);
   // inputs move only just after a clock edge, like a driven pin
   initial captureIn = 3'h0;
   always @(posedge core_clk) begin
      captureIn <= level;
   end
endmodule // capture_source

// ==== input_capture_checker.sv ====
// port assertions for input capture control
`timescale 1ns/1ps
`include "input_capture_consts.vh"
module input_capture_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`CAP_AW-1:0] paddr,
   input wire logic [`CAP_DW-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [`CAP_DW-1:0] prdata,
   input wire logic pslverr,
   input wire logic [`CAP_NCH-1:0] captureIn,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic acc, wr, selSet_q, mask0_q;
   logic [3:0] quiet_q;
   logic [2:0] inPrev_q;
   assign acc = psel && penable;
   assign wr = acc && pwrite && pstrb[0];
   // quiet_q saturates so a long idle never wraps into a false cause
   always @(posedge core_clk) begin
      inPrev_q <= captureIn;
      if (!rst_n) begin
         selSet_q <= 1'b0;
         mask0_q <= 1'b1;
         quiet_q <= 4'hf;
      end else begin
         if (wr && paddr == {`CAP_IDX_EDGESEL, 2'b00}) selSet_q <= 1'b1;
         if (wr && paddr == {`CAP_IDX_INTMASK, 2'b00})
            mask0_q <= (pwdata[2:0] == 3'h0);
         if (captureIn != inPrev_q) quiet_q <= 4'h0;
         else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
      end
   end
   a_ready_nowait: assert property (pready == acc)
      else $error("pready differs from access phase");
   a_err_access: assert property (pslverr |-> acc)
      else $error("pslverr outside access phase");
   a_err_misalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   a_err_nodata: assert property (acc && pslverr |-> prdata == 32'h0)
      else $error("refused access returned data");
   a_map_ok: assert property (acc && paddr == {`CAP_IDX_ENFLAG, 2'b00}
      |-> !pslverr) else $error("mapped register refused");
   a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
      else $error("read data above byte not zero");
   a_sel_reset: assert property (acc && !pwrite && !selSet_q &&
      paddr == {`CAP_IDX_EDGESEL, 2'b00} |-> prdata == 32'h0)
      else $error("edge select not zero after reset");
   a_irq_masked: assert property (mask0_q && $past(mask0_q) |-> !irq)
      else $error("irq high with mask empty");
   a_irq_cause: assert property ($rose(irq) |-> quiet_q < 4'hc ||
      $past(wr)) else $error("irq rose without input or write");
endmodule // input_capture_checker
bind input_capture_control input_capture_checker i_input_capture_checker (
   .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .captureIn(captureIn), .irq(irq));

// ==== input_capture_control_bench.sv ====
// self-checking bench for input capture control
`timescale 1ns/1ps
`include "input_capture_consts.vh"
module input_capture_control_bench;
   logic core_clk = 1'b0, rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, seed = 32'h64fe, rd, err, v;
   logic [3:0] pstrb = 4'h0, stb = 4'h1;
   logic [2:0] lvl = 3'h0;
   wire pready, pslverr, irq;
   wire [31:0] prdata;
   wire [2:0] captureIn;
   int errors = 0, compares = 0;
   localparam logic [11:0] AEF = {`CAP_IDX_ENFLAG, 2'b00};
   localparam logic [11:0] ASEL = {`CAP_IDX_EDGESEL, 2'b00};
   localparam logic [11:0] AFIL = {`CAP_IDX_FILTER, 2'b00};
   localparam logic [11:0] AST = {`CAP_IDX_INTSTAT, 2'b00};
   localparam logic [11:0] AMSK = {`CAP_IDX_INTMASK, 2'b00};
   localparam logic [59:0] AM = {AMSK, AST, AFIL, ASEL, AEF};
   always #20 core_clk = ~core_clk;
   input_capture_control i_input_capture_control (.core_clk(core_clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .captureIn(captureIn), .irq(irq));
   capture_source i_capture_source (.core_clk(core_clk), .level(lvl),
      .captureIn(captureIn));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // the reserved code is mapped away so software never writes it
   function automatic logic [1:0] cs(input logic [1:0] c);
      return (c == 2'h3) ? 2'h2 : c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= stb;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         errors++;
         give_verdict;
      end else begin
         rd = prdata;
         err = {31'h0, pslverr};
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic step(input logic [2:0] lv, input int ch, input logic hit);
      lvl <= lv;
      repeat (14) @(posedge core_clk);
      apb(0, AEF, 0);
      chk(rd, (32'h10 << ch) | (32'(hit) << ch));
      chk(32'(irq), 32'(hit));
      apb(0, AST, 0);
      chk(rd, 32'(hit) << ch);
      apb(1, AEF, 32'h10 << ch);
      apb(1, AST, 32'h7);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(0, AM[12*i +: 12], 0);
         chk(rd, 0);
      end
      apb(0, 12'h000, 0);
      chk(err, 1);
      apb(1, AEF + 12'h1, 32'h77);
      chk(err, 1);
      apb(0, AEF, 0);
      chk(rd, 0);
      repeat (6) begin
         seed = xs(seed);
         v = {26'h0, cs(seed[5:4]), cs(seed[3:2]), cs(seed[1:0])};
         apb(1, ASEL, v);
         stb = 4'h0;
         apb(1, ASEL, ~v & 32'h3f);
         stb = 4'h1;
         apb(0, ASEL, 0);
         chk(rd, v);
         apb(1, AFIL, seed[15:8] & 8'h70);
         apb(0, AFIL, 0);
         chk(rd, {24'h0, seed[15:8] & 8'h70});
         apb(1, AEF, seed[23:16] & 8'h70);
         apb(0, AEF, 0);
         chk(rd, {24'h0, seed[23:16] & 8'h70});
      end
      apb(1, AMSK, 32'h7);
      for (int f = 0; f < 2; f++)
         for (int c = 0; c < 3; c++)
            for (int ch = 0; ch < 3; ch++) begin
               apb(1, ASEL, c << (2 * ch));
               apb(1, AFIL, f << (4 + ch));
               apb(1, AEF, 32'h10 << ch);
               step(3'h7, ch, c != 0);
               step(3'h0, ch, c != 1);
            end
      apb(1, ASEL, 32'h2);
      for (int f = 0; f < 2; f++) begin
         apb(1, AFIL, 32'h10 * f);
         apb(1, AEF, 32'h10);
         lvl <= 3'h1;
         repeat (2) @(posedge core_clk);
         lvl <= 3'h0;
         repeat (14) @(posedge core_clk);
         apb(0, AEF, 0);
         chk(rd, 32'h10 | (f == 0));
      end
      apb(1, AMSK, 0);
      lvl <= 3'h1;
      repeat (14) @(posedge core_clk);
      chk(32'(irq), 0);
      apb(0, AST, 0);
      chk(rd, 1);
      apb(1, AMSK, 1);
      @(posedge core_clk);
      chk(32'(irq), 1);
      apb(1, AST, 1);
      @(posedge core_clk);
      chk(32'(irq), 0);
      give_verdict;
   end
endmodule // input_capture_control_bench
